// *** tb/tpf_flags_mailbox_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================
// bench: word out port, byte in port, little endian
module tpf_flags_mailbox_tb;
    localparam int DEPTH = 16;
    localparam logic [15:0] SER_OFS = 16'h8880; // y1 x1 y2 x2 as 8 8 8 0
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clkEn = 1'b1;
    logic masterResetOneN = 1'b0, masterResetTwoN = 1'b0, endianSelect = 1'b0;
    logic outPortWidthSel = 1'b0, inPortWidthSel = 1'b1, fallThroughMode = 1'b0;
    logic offsetProgEnable = 1'b0, offsetSerialEnable = 1'b0, offsetSerialData = 1'b0;
    logic widePortClock, widePortSelectN, widePortDirection, widePortEnable, widePortMailSelect;
    logic outPortClock, outPortSelectN, outPortReadEnable, outPortMailSelect;
    logic inPortClock, inPortWriteEnable, inPortMailSelect, widePortDataOe, outPortDataOe;
    logic [35:0] widePortDataIn, widePortDataOut;
    logic [17:0] inPortData, outPortData;
    logic fifo2RdSideSpaceFlag, fifo2WrSpaceFlag, fifo1AlmostFullFlag, fifo2AlmostFullFlag;
    logic fifo1AlmostEmptyFlag, fifo2AlmostEmptyFlag, mailOneFullN, mailTwoFullN;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    tpf_port_master pm (.*);
    tpf_flags_mailbox #(.DEPTH(DEPTH)) dut (.*);
    // core clock
    initial forever #5 core_clk = ~core_clk;
    // =====================================
    // helpers
    task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic waitc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard, far above the few thousand cycles needed
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            give_verdict();
        end
    end
    // =====================================
    // main sequence
    initial begin
        waitc(4);
        rst_b = 1'b1;
        waitc(8);
        {masterResetOneN, masterResetTwoN} = 2'h3;
        for (int k = 0; k < 100 && {fifo2RdSideSpaceFlag, fifo2WrSpaceFlag} !== 2'h3; k++) waitc(1);
        check("idle flags", {mailOneFullN, mailTwoFullN, fifo1AlmostEmptyFlag, fifo2AlmostEmptyFlag,
            fifo1AlmostFullFlag, fifo2AlmostFullFlag, fifo2RdSideSpaceFlag, fifo2WrSpaceFlag}, 8'hCF);
        check("oe idle", {widePortDataOe, outPortDataOe}, 2'h0);
        // serial offsets, one bit per wide edge
        for (int s = 15; s >= 0; s--) begin
            @(negedge widePortClock);
            {offsetSerialEnable, offsetSerialData} = {1'b1, SER_OFS[s]};
        end
        @(negedge widePortClock);
        offsetSerialEnable = 1'b0;
        // mail one: second write refused while full
        pm.wideOp(1'b1, 1'b1, 36'hA_BCDE_1234);
        pm.wideOp(1'b1, 1'b1, 36'h0_0000_0055);
        check("mail_reg_out flag", mailOneFullN, 1'b0);
        pm.outOp(1'b1);
        check("mail_reg_out data", outPortData, 18'h2_1234);
        pm.outOp(1'b1);
        check("mail_reg_out kept", {mailOneFullN, outPortData}, {1'b1, 18'h2_1234});
        // mail two in byte size keeps nine bits
        pm.inOp(1'b1, 18'h3_FFFF);
        check("mail_reg_in flag", mailTwoFullN, 1'b0);
        pm.wideOp(1'b0, 1'b1, 36'h0_0000_0000);
        check("mail_reg_in data", {mailTwoFullN, widePortDataOut}, {1'b1, 18'h0_01FF, 18'h0_0000});
        // frozen core misses an in-port mail write
        clkEn = 1'b0;
        pm.inOp(1'b1, 18'h0_0077);
        clkEn = 1'b1;
        waitc(4);
        check("frozen", mailTwoFullN, 1'b1);
        // fifo1 filled to full, flags at the offset boundaries
        for (int i = 1; i <= 18; i++) begin
            if (i == 10) begin
                pm.outOp(1'b0);
                check("lane one", outPortData, 18'h0_0001);
                pm.outOp(1'b0);
                check("lane two", outPortData, 18'h0_0101);
                waitc(40);
                check("ae reg", fifo1AlmostEmptyFlag, 1'b0);
            end
            pm.wideOp(1'b1, 1'b0, (i == 18) ? 36'h0_0000_0063 : {18'(i + 256), 18'(i)});
            waitc(40);
            if (i >= 7 && i <= 9) check("ae af", {fifo1AlmostEmptyFlag, fifo1AlmostFullFlag}, {i == 9, i == 7});
        end
        check("full", fifo2RdSideSpaceFlag, 1'b0);
        // drain; the refused write must not appear
        for (int j = 2; j <= 17; j++) begin
            pm.outOp(1'b0);
            check("drain lo", outPortData, 18'(j));
            pm.outOp(1'b0);
            check("drain hi", outPortData, 18'(j + 256));
            waitc(30);
            if (j == 2) check("space back", fifo2RdSideSpaceFlag, 1'b1);
        end
        pm.outOp(1'b0);
        check("empty hold", outPortData, 18'(17 + 256));
        // fifo2 byte writes, first byte lands lowest
        for (int b = 1; b <= 4; b++) pm.inOp(1'b0, 18'(b * 17));
        waitc(40);
        check("ae two", fifo2AlmostEmptyFlag, 1'b1);
        pm.wideOp(1'b0, 1'b0, 36'h0_0000_0000);
        check("fifo2 word", widePortDataOut, {9'h044, 9'h033, 9'h022, 9'h011});
        check("ae two low", fifo2AlmostEmptyFlag, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire

// *** tb/tpf_port_master.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================
// bus masters of the three ports
module tpf_port_master (
    // core timing
    input  wire logic        core_clk,
    // wide port
    output logic             widePortClock,
    output logic             widePortSelectN,
    output logic             widePortDirection,
    output logic             widePortEnable,
    output logic             widePortMailSelect,
    output logic      [35:0] widePortDataIn,
    // out port
    output logic             outPortClock,
    output logic             outPortSelectN,
    output logic             outPortReadEnable,
    output logic             outPortMailSelect,
    // in port
    output logic             inPortClock,
    output logic             inPortWriteEnable,
    output logic             inPortMailSelect,
    output logic      [17:0] inPortData
);
    int cyc = 0;
    // mail select held
    // in-port mail select idles high, so it covers master reset
    initial begin
        {widePortClock, outPortClock, inPortClock} = 3'h0;
        {widePortSelectN, widePortEnable, widePortDirection, widePortMailSelect} = 4'h8;
        {outPortSelectN, outPortReadEnable, outPortMailSelect} = 3'h4;
        {inPortWriteEnable, inPortMailSelect} = 2'h1;
        widePortDataIn = 36'h0_0000_0000;
        inPortData = 18'h0_0000;
    end
    // free-running port clocks at unequal rates, slow against core
    always @(negedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc % 4 == 3) widePortClock <= ~widePortClock;
        if (cyc % 5 == 4) outPortClock <= ~outPortClock;
        if (cyc % 3 == 2) inPortClock <= ~inPortClock;
    end
    // wide transfers
    // held from a falling port edge across the rising one
    task automatic wideOp(input logic wr, input logic mb, input logic [35:0] d);
        @(negedge widePortClock);
        {widePortSelectN, widePortEnable, widePortDirection, widePortMailSelect} = {2'h1, wr, mb};
        widePortDataIn = d;
        @(negedge widePortClock);
        {widePortSelectN, widePortEnable} = 2'h2;
        widePortDataIn = ~d;  // released bus shows no stale value
        repeat (2) @(negedge core_clk);
    endtask
    task automatic outOp(input logic mb);
        @(negedge outPortClock);
        {outPortSelectN, outPortReadEnable, outPortMailSelect} = {2'h1, mb};
        @(negedge outPortClock);
        {outPortSelectN, outPortReadEnable} = 2'h2;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic inOp(input logic mb, input logic [17:0] d);
        @(negedge inPortClock);
        {inPortWriteEnable, inPortMailSelect} = {1'b1, mb};
        inPortData = d;
        @(negedge inPortClock);
        {inPortWriteEnable, inPortMailSelect} = 2'h1;
        inPortData = ~d;
        repeat (2) @(negedge core_clk);
    endtask
endmodule
`default_nettype wire

// *** verilog/tpf_defines.svh ***
// Contract
// RQ1: space flag high while a location is free; writes ignored when low.
// RQ2: space flag serves as input-ready or active-low full per mode.
// RQ3: space flag rises on second writing-port edge after freeing read.
// RQ4: writing edge too close to the read counts from the next edge.
// RQ5: almost-empty low at X or fewer words, high at X+1 or more.
// RQ6: word held in output register excluded from flag word counts.
// RQ7: almost-empty rises on second reading-port edge after the write.
// RQ8: offsets preset at reset, written from wide port, or shifted serially.
// RQ9: almost-full low at depth minus Y or more words, high below.
// RQ10: almost-full rises on second writing-port edge after the read.
// RQ11: two 18-bit mail registers bypass both queues.
// RQ12: mail one written by wide-port mail write, A0-A17 or A0-A8.
// RQ13: mail two written by in-port mail write, C0-C17 or C0-C8.
// RQ14: mail write drives its full flag low; later writes ignored meanwhile.
// RQ15: port data comes from FIFO when mail select low, else mail.
// RQ16: out-port mail read sets mail one flag high, data on B lines.
// RQ17: wide-port mail read sets mail two flag high, data on A18 up.
// RQ18: mail contents survive reads, change only on writes, no reordering.
// RQ19: controller holds in-port mail select high during master reset.
// RQ20: port widths latched at master reset release, held static after.
// RQ21: endian level caught at master reset release, used by both ports.
// RQ22: memories hold only 36-bit words; width matching around them.
// RQ23: each flag passes two stages clocked by its port edge.
// RQ24: both mail flags read empty after master reset.
`ifndef TPF_DEFINES_SVH
`define TPF_DEFINES_SVH
// =====================================
// sizes and presets
`define TPF_DEPTH      2048
`define TPF_OFS_PRESET 16'h0008
// =====================================
// flag vector positions and reset value
`define TPF_F_SP1      0
`define TPF_F_AF1      1
`define TPF_F_AE1      2
`define TPF_F_SP2      3
`define TPF_F_AF2      4
`define TPF_F_AE2      5
`define TPF_FLAG_RST   6'h12
`define TPF_LAST_WORD  2'h1
`define TPF_LAST_BYTE  2'h3
`endif

// *** verilog/tpf_flags_mailbox.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tpf_defines.svh"
module tpf_flags_mailbox
    import tpf_pkg::*;
#(
    parameter int DEPTH = `TPF_DEPTH
) (
    // core clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        clkEn,
    // wide port
    input  wire logic        widePortClock,
    input  wire logic        widePortSelectN,
    input  wire logic        widePortDirection,
    input  wire logic        widePortEnable,
    input  wire logic        widePortMailSelect,
    input  wire logic [35:0] widePortDataIn,
    output logic      [35:0] widePortDataOut,
    output logic             widePortDataOe,
    // out port
    input  wire logic        outPortClock,
    input  wire logic        outPortSelectN,
    input  wire logic        outPortReadEnable,
    input  wire logic        outPortMailSelect,
    output logic      [17:0] outPortData,
    output logic             outPortDataOe,
    // in port
    input  wire logic        inPortClock,
    input  wire logic        inPortWriteEnable,
    input  wire logic        inPortMailSelect,
    input  wire logic [17:0] inPortData,
    // configuration pins
    input  wire logic        masterResetOneN,
    input  wire logic        masterResetTwoN,
    input  wire logic        endianSelect,
    input  wire logic        outPortWidthSel,
    input  wire logic        inPortWidthSel,
    input  wire logic        fallThroughMode,
    input  wire logic        offsetProgEnable,
    input  wire logic        offsetSerialEnable,
    input  wire logic        offsetSerialData,
    // flags
    output logic             fifo2RdSideSpaceFlag,
    output logic             fifo2WrSpaceFlag,
    output logic             fifo1AlmostFullFlag,
    output logic             fifo2AlmostFullFlag,
    output logic             fifo1AlmostEmptyFlag,
    output logic             fifo2AlmostEmptyFlag,
    output logic             mailOneFullN,
    output logic             mailTwoFullN
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULLC = (AW+1)'(DEPTH);

    // =====================================
    // helpers
    function automatic logic [1:0] lanePos(input logic byteM, input logic bigE, input logic [1:0] k);
        lanePos = bigE ? ((byteM ? `TPF_LAST_BYTE : `TPF_LAST_WORD) - k) : k;
    endfunction
    function automatic logic [17:0] getLane(input logic [35:0] w, input logic byteM, input logic [1:0] p);
        getLane = byteM ? {9'h000, w[9*p +: 9]} : w[18*p[0] +: 18];
    endfunction
    function automatic logic [35:0] putLane(input logic [35:0] w, input logic byteM, input logic [1:0] p,
                                            input logic [17:0] d);
        logic [35:0] r;
        r = w;
        if (byteM) begin
            r[9*p +: 9] = d[8:0];
        end else begin
            r[18*p[0] +: 18] = d;
        end
        putLane = r;
    endfunction
    function automatic logic aeRaw(input logic [AW:0] c, input logic [AW-1:0] x);
        aeRaw = c > {1'b0, x};
    endfunction
    function automatic logic afRaw(input logic [AW:0] c, input logic [AW-1:0] y);
        afRaw = ({1'b0, c} + {2'b00, y}) < {1'b0, FULLC};
    endfunction

    // =====================================
    // pin synchronisers
    tpf_wide_s  a1, a2;
    tpf_out_s   b1, b2;
    tpf_in_s    c1, c2;
    tpf_cfg_s   g1, g2;
    logic [2:0] clkQ;
    // stage one feeds stage two only; edges use stage two
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            {a1, b1, c1, g1} <= '0;
            {a2, b2, c2, g2} <= '0;
            clkQ             <= 3'h0;
        end else if (clkEn) begin
            a1   <= {widePortClock, widePortSelectN, widePortDirection, widePortEnable, widePortMailSelect,
                     widePortDataIn};
            b1   <= {outPortClock, outPortSelectN, outPortReadEnable, outPortMailSelect};
            c1   <= {inPortClock, inPortWriteEnable, inPortMailSelect, inPortData};
            g1   <= {masterResetOneN, masterResetTwoN, endianSelect, outPortWidthSel, inPortWidthSel,
                     fallThroughMode, offsetProgEnable, offsetSerialEnable, offsetSerialData};
            {a2, b2, c2, g2} <= {a1, b1, c1, g1};
            clkQ <= {a2.clk, b2.clk, c2.clk};
        end
    end

    logic aEdge, bEdge, cEdge, mr1Ok, mr2Ok;
    assign aEdge = a2.clk & ~clkQ[2];
    assign bEdge = b2.clk & ~clkQ[1];
    assign cEdge = c2.clk & ~clkQ[0];
    assign mr1Ok = g2.mr1N;
    assign mr2Ok = g2.mr2N;

    // =====================================
    // configuration latched at reset release
    logic mr1Q, mr2Q, outByte, inByte, bigEnd, fall_through_mode;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            {mr1Q, mr2Q, outByte, inByte, bigEnd, fall_through_mode} <= 6'h00;
        end else if (clkEn) begin
            mr1Q <= mr1Ok;
            mr2Q <= mr2Ok;
            // RQ20 width at release
            if (mr1Ok && !mr1Q) begin
                outByte <= g2.outByte;
            end
            if (mr2Ok && !mr2Q) begin
                inByte <= g2.inByte;
            end
            // RQ21 endian at release
            if ((mr1Ok && mr2Ok) && !(mr1Q && mr2Q)) begin
                bigEnd <= g2.endian;
                fall_through_mode   <= g2.fall_through_mode;
            end
        end
    end

    // =====================================
    // port requests; each gated off by the master reset of the FIFO or mail register it uses
    logic aSel, aWr, aRd, wr1, rd2, aMailWr, aMailRd, progWr;
    logic bRd, rd1, bMailRd, cWr, wr2, cMailWr;
    logic [AW:0] wp1, rp1, wp2, rp2, cnt1, cnt2;
    assign aSel    = ~a2.selN & a2.en;
    assign aWr     = aEdge & aSel & a2.dir;
    assign aRd     = aEdge & aSel & ~a2.dir;
    // RQ1 writes need space
    assign wr1     = aWr & ~a2.mail & ~g2.progEn & fifo2RdSideSpaceFlag;
    assign progWr  = aWr & ~a2.mail & g2.progEn & mr1Ok & mr2Ok;
    assign rd2     = aRd & ~a2.mail & mr2Ok & (cnt2 != '0);
    // RQ19 mail ignored in reset
    assign aMailWr = aWr & a2.mail & mr1Ok;
    assign aMailRd = aRd & a2.mail & mr2Ok;
    assign bRd     = bEdge & ~b2.selN & b2.rdEn & mr1Ok;
    assign rd1     = bRd & ~b2.mail;
    assign bMailRd = bRd & b2.mail;
    assign cWr     = cEdge & c2.wrEn & mr2Ok;
    assign cMailWr = cWr & c2.mail;
    assign wr2     = cWr & ~c2.mail & fifo2WrSpaceFlag;
    // RQ6 counts exclude output register
    assign cnt1    = wp1 - rp1;
    assign cnt2    = wp2 - rp2;

    // =====================================
    // offsets: y1, x1, y2, x2 from top
    logic [3:0][AW-1:0] ofs;
    logic [1:0]         progIdx;
    // RQ8 preset, parallel, serial
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ofs     <= {4{AW'(`TPF_OFS_PRESET)}};
            progIdx <= 2'h0;
        end else if (clkEn) begin
            if (!mr1Ok || !mr2Ok) begin
                progIdx <= 2'h0;
                if (!mr1Ok) begin
                    ofs[3] <= AW'(`TPF_OFS_PRESET);
                    ofs[2] <= AW'(`TPF_OFS_PRESET);
                end
                if (!mr2Ok) begin
                    ofs[1] <= AW'(`TPF_OFS_PRESET);
                    ofs[0] <= AW'(`TPF_OFS_PRESET);
                end
            end else if (progWr) begin
                ofs[2'h3 - progIdx] <= a2.data[AW-1:0];
                progIdx             <= progIdx + 2'h1;
            end else if (aEdge && g2.serEn) begin
                ofs <= (4*AW)'({ofs, g2.serData}); // first bit shifted ends in y1
            end
        end
    end

    // =====================================
    // long-word memories
    logic [35:0] mem1 [DEPTH];
    logic [35:0] mem2 [DEPTH];
    logic [35:0] acc2;
    logic [1:0]  inIdx;
    logic [1:0]  inPos;
    assign inPos = lanePos(inByte, bigEnd, inIdx);
    // RQ22 only whole words stored
    always_ff @(posedge core_clk) begin
        if (clkEn && wr1) begin
            mem1[wp1[AW-1:0]] <= a2.data;
        end
        if (clkEn && wr2 && inIdx == (inByte ? `TPF_LAST_BYTE : `TPF_LAST_WORD)) begin
            mem2[wp2[AW-1:0]] <= putLane(acc2, inByte, inPos, c2.data);
        end
    end

    // write pointers and in-port assembly
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wp1   <= '0;
            wp2   <= '0;
            acc2  <= 36'h0_0000_0000;
            inIdx <= 2'h0;
        end else if (clkEn) begin
            if (!mr1Ok) begin
                wp1 <= '0;
            end else if (wr1) begin
                wp1 <= wp1 + 1'b1;
            end
            if (!mr2Ok) begin
                wp2   <= '0;
                inIdx <= 2'h0;
            end else if (wr2) begin
                // RQ22 width matching before write
                acc2  <= putLane(acc2, inByte, inPos, c2.data);
                inIdx <= inIdx + 2'h1;
                if (inIdx == (inByte ? `TPF_LAST_BYTE : `TPF_LAST_WORD)) begin
                    wp2   <= wp2 + 1'b1;
                    inIdx <= 2'h0;
                end
            end
        end
    end

    // =====================================
    // out-port read side with lane unpacking
    logic [17:0] mail_reg_out, mail_reg_in;
    logic [35:0] hold1, word1;
    logic [2:0]  avail1, availNow1;
    logic [1:0]  idx1, kNow1;
    logic        canFetch1, fetch1, take1;
    assign word1     = (avail1 == 3'h0) ? mem1[rp1[AW-1:0]] : hold1;
    assign kNow1     = (avail1 == 3'h0) ? 2'h0 : idx1;
    assign availNow1 = (avail1 == 3'h0) ? (outByte ? 3'h4 : 3'h2) : avail1;
    assign canFetch1 = (avail1 == 3'h0) && (cnt1 != '0) && mr1Ok;
    assign take1     = rd1 && ((avail1 != 3'h0) || (canFetch1 && !fall_through_mode));
    // fall-through mode prefetches a word ahead of the first read
    assign fetch1    = canFetch1 && (fall_through_mode || rd1);
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rp1         <= '0;
            hold1       <= 36'h0_0000_0000;
            avail1      <= 3'h0;
            idx1        <= 2'h0;
            outPortData <= 18'h0_0000;
        end else if (clkEn) begin
            if (!mr1Ok) begin
                rp1    <= '0;
                avail1 <= 3'h0;
                idx1   <= 2'h0;
            end else begin
                if (fetch1) begin
                    rp1    <= rp1 + 1'b1;
                    hold1  <= word1;
                    avail1 <= availNow1;
                    idx1   <= 2'h0;
                end
                // RQ15 FIFO source
                if (take1) begin
                    outPortData <= getLane(word1, outByte, lanePos(outByte, bigEnd, kNow1));
                    idx1        <= kNow1 + 2'h1;
                    avail1      <= availNow1 - 3'h1;
                end
                // RQ16 mail source
                if (bMailRd) begin
                    outPortData <= mail_reg_out;
                end
            end
        end
    end
    assign outPortDataOe = ~b2.selN;

    // =====================================
    // wide-port read side
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rp2             <= '0;
            widePortDataOut <= 36'h0_0000_0000;
        end else if (clkEn) begin
            if (!mr2Ok) begin
                rp2 <= '0;
            end else if (rd2) begin
                rp2             <= rp2 + 1'b1;
                widePortDataOut <= mem2[rp2[AW-1:0]];
            end else if (aMailRd) begin
                // RQ17 mail on upper lines
                widePortDataOut <= {mail_reg_in, 18'h0_0000};
            end
        end
    end
    assign widePortDataOe = aSel & ~a2.dir;

    // =====================================
    // flag synchronisers, each stepped by its own port edge
    logic [5:0] rawF, edgeF, fs1, fs2;
    assign rawF  = {aeRaw(cnt2, ofs[0]), afRaw(cnt2, ofs[1]), (cnt2 < FULLC) & mr2Ok,
                    aeRaw(cnt1, ofs[2]), afRaw(cnt1, ofs[3]), (cnt1 < FULLC) & mr1Ok};
    assign edgeF = {aEdge, cEdge, cEdge, bEdge, aEdge, aEdge};
    // RQ23 RQ3 RQ7 RQ10 two-edge rise
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fs1 <= `TPF_FLAG_RST;
            fs2 <= `TPF_FLAG_RST;
        end else if (clkEn) begin
            for (int i = 0; i < 6; i++) begin
                if (edgeF[i]) begin
                    fs1[i] <= rawF[i];
                    fs2[i] <= fs1[i];
                end
            end
            // a short master reset may see no port edge, so empty the space stages here
            if (!mr1Ok) begin
                fs1[`TPF_F_SP1] <= 1'b0;
                fs2[`TPF_F_SP1] <= 1'b0;
            end
            if (!mr2Ok) begin
                fs1[`TPF_F_SP2] <= 1'b0;
                fs2[`TPF_F_SP2] <= 1'b0;
            end
        end
    end
    // RQ4 raw lags event one cycle
    // flags fall at once with the raw term and rise only after two edges
    // RQ2 one flag, both modes
    assign fifo2RdSideSpaceFlag = fs2[`TPF_F_SP1] & rawF[`TPF_F_SP1];
    assign fifo2WrSpaceFlag     = fs2[`TPF_F_SP2] & rawF[`TPF_F_SP2];
    // RQ9 almost-full thresholds
    assign fifo1AlmostFullFlag  = fs2[`TPF_F_AF1] & rawF[`TPF_F_AF1];
    assign fifo2AlmostFullFlag  = fs2[`TPF_F_AF2] & rawF[`TPF_F_AF2];
    // RQ5 almost-empty thresholds
    assign fifo1AlmostEmptyFlag = fs2[`TPF_F_AE1] & rawF[`TPF_F_AE1];
    assign fifo2AlmostEmptyFlag = fs2[`TPF_F_AE2] & rawF[`TPF_F_AE2];

    // =====================================
    // mail registers
    // RQ11 bypass registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mail_reg_out        <= 18'h0_0000;
            mail_reg_in        <= 18'h0_0000;
            mailOneFullN <= 1'b1;
            mailTwoFullN <= 1'b1;
        end else if (clkEn) begin
            // RQ24 empty after reset
            if (!mr1Ok) begin
                mailOneFullN <= 1'b1;
            // RQ12 RQ14 write wins
            end else if (aMailWr && mailOneFullN) begin
                mail_reg_out        <= outByte ? {9'h000, a2.data[8:0]} : a2.data[17:0];
                mailOneFullN <= 1'b0;
            end else if (bMailRd) begin
                mailOneFullN <= 1'b1;
            end
            if (!mr2Ok) begin
                mailTwoFullN <= 1'b1;
            // RQ13 RQ18 write only changes
            end else if (cMailWr && mailTwoFullN) begin
                mail_reg_in        <= inByte ? {9'h000, c2.data[8:0]} : c2.data;
                mailTwoFullN <= 1'b0;
            end else if (aMailRd) begin
                mailTwoFullN <= 1'b1;
            end
        end
    end

    // =====================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b || !clkEn);
    sequence s_m1_wr; aMailWr && mailOneFullN; endsequence
    sequence s_m1_rd; bMailRd && !aMailWr; endsequence
    property p_space_block; mr1Ok && aWr && !a2.mail && !fifo2RdSideSpaceFlag |=> $stable(wp1); endproperty
    a_space_block: assert property (p_space_block) else $error("write taken with no space"); // RQ1
    property p_full_low; cnt1 == FULLC |-> !fifo2RdSideSpaceFlag; endproperty
    a_full_low: assert property (p_full_low) else $error("space flag high when full"); // RQ1
    property p_sp_rise; $rose(fifo2WrSpaceFlag) |-> $past(fs1[`TPF_F_SP2]) && rawF[`TPF_F_SP2]; endproperty
    a_sp_rise: assert property (p_sp_rise) else $error("space flag rose unsynchronised"); // RQ3
    property p_ae; fifo1AlmostEmptyFlag |-> cnt1 > {1'b0, ofs[2]}; endproperty
    a_ae: assert property (p_ae) else $error("almost-empty high at X or fewer"); // RQ5
    property p_af; (cnt2 + ofs[1]) >= FULLC |-> !fifo2AlmostFullFlag; endproperty
    a_af: assert property (p_af) else $error("almost-full high near full"); // RQ9
    property p_m1_set; s_m1_wr |=> !mailOneFullN && mail_reg_out[8:0] == $past(a2.data[8:0]); endproperty
    a_m1_set: assert property (p_m1_set) else $error("mail write did not fill"); // RQ14
    property p_m1_hold; aMailWr && !mailOneFullN && !bMailRd |=> $stable(mail_reg_out) && !mailOneFullN; endproperty
    a_m1_hold: assert property (p_m1_hold) else $error("write to full mail accepted"); // RQ14
    property p_m1_rd; s_m1_rd |=> mailOneFullN && outPortData == mail_reg_out && $stable(mail_reg_out); endproperty
    a_m1_rd: assert property (p_m1_rd) else $error("mail read wrong"); // RQ16
    property p_m2_rd; aMailRd && !cMailWr |=> mailTwoFullN && widePortDataOut[35:18] == mail_reg_in; endproperty
    a_m2_rd: assert property (p_m2_rd) else $error("mail two read wrong"); // RQ17
    property p_mr; !mr1Ok |=> mailOneFullN && !fifo2RdSideSpaceFlag; endproperty
    a_mr: assert property (p_mr) else $error("reset state wrong"); // RQ24
endmodule
`default_nettype wire

// *** verilog/tpf_pkg.sv ***
`default_nettype none
package tpf_pkg;
    // =====================================
    // sampled pin groups
    typedef struct packed {
        logic        clk;
        logic        selN;
        logic        dir;
        logic        en;
        logic        mail;
        logic [35:0] data;
    } tpf_wide_s;
    typedef struct packed {
        logic clk;
        logic selN;
        logic rdEn;
        logic mail;
    } tpf_out_s;
    typedef struct packed {
        logic        clk;
        logic        wrEn;
        logic        mail;
        logic [17:0] data;
    } tpf_in_s;
    typedef struct packed {
        logic mr1N;
        logic mr2N;
        logic endian;
        logic outByte;
        logic inByte;
        logic fall_through_mode;
        logic progEn;
        logic serEn;
        logic serData;
    } tpf_cfg_s;
endpackage
`default_nettype wire
